// ===== hdl/tbmc_regs.vh
`ifndef TBMC_REGS_VH
`define TBMC_REGS_VH

// register byte offsets inside the control window
`define TBMC_POSITION_OFF      12'h000
`define TBMC_MASTER_OFF        12'h004
`define TBMC_FLOW_OFF          12'h008

// master control fields
`define TBMC_MASTER_EN_BIT     31
`define TBMC_MASTER_HALT_BIT   9
`define TBMC_MASTER_BPRIV_BIT  8
`define TBMC_MASTER_WPRIV_BIT  7
`define TBMC_MASTER_STOP_BIT   6
`define TBMC_MASTER_START_BIT  5
`define TBMC_MASTER_MASK_MSB   4
`define TBMC_MASTER_MASK_LSB   0
`define TBMC_MASTER_RESET      32'h0000_0000

// position fields: pointer bits 14:3 active, wrap at bit 2
`define TBMC_PTR_MSB           14
`define TBMC_PTR_LSB           3
`define TBMC_PTR_W             12
`define TBMC_WRAP_BIT          2
`define TBMC_POSITION_RESET    32'h0000_0000

// flow fields: watermark as pointer, autohalt bit 1, autostop bit 0
`define TBMC_FLOW_HALT_BIT     1
`define TBMC_FLOW_STOP_BIT     0
`define TBMC_FLOW_RESET        32'h0000_0000

// largest usable mask value for a 12-bit pointer
`define TBMC_MASK_MAX          5'h0b

// protection bit that marks a privileged access
`define TBMC_HPROT_PRIV_BIT    1

`endif

// ===== hdl/tbmc_master_ctrl.v
`timescale 1ns/1ps
`include "tbmc_regs.vh"

// Function
// - enabled: write packet, then advance pointer
// - watermark autostop clears trace enable
// - start input with allow sets enable
// - stop input clears enable after packet write
// - autostop blocks start until pointer/watermark change
// - master bits 30..10 read zero
// - halt out = halt bit and debug allow
// - watermark autohalt sets halt bit
// - buffer privileged bit blocks user RAM access
// - user/privileged taken from HPROT[1] only
// - write privileged bit blocks user register writes
// - mask sets circular buffer size
// - wrap sets flag, clears low bits
// - oversize mask acts as largest mask
// - master writable, hardware updates enable/halt
// - pointer bits 14:3 active, wrap bit 2
// - pointer equals watermark triggers stop/halt
module tbmc_master_ctrl (
  input  wire        sys_clk,
  input  wire        rst,
  // ahb-lite control register slave
  input  wire        hsel_reg,
  input  wire        hsel_ram,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [3:0]  hprot,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hready_out,
  output wire        hresp,
  // bus path to trace ram
  output wire        bus_ram_en,
  output wire        bus_ram_we,
  output wire [9:0]  bus_ram_addr,
  output wire [31:0] bus_ram_wdata,
  input  wire [31:0] bus_ram_rdata,
  // trace packets from the core
  input  wire        pkt_valid,
  output wire        pkt_ready,
  input  wire [63:0] pkt_data,
  output reg         trace_ram_we,
  output reg  [12:0] trace_ram_addr,
  output reg  [31:0] trace_ram_wdata,
  // external pins
  input  wire        trace_start_in,
  input  wire        trace_stop_in,
  input  wire        invasive_debug_allow,
  output wire        debug_halt_out
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOW  = 3'b010;
  localparam [2:0] ST_HIGH = 3'b100;

  reg  [2:0]  pin_s1_reg;
  reg  [2:0]  pin_s2_reg;
  reg  [2:0]  pin_s3_reg;
  reg  [2:0]  pin_lvl_reg;
  reg         en_reg;
  reg         halt_request_bit;
  reg         buffer_privileged_only;
  reg         control_write_privileged;
  reg         stop_input_allow;
  reg         start_input_allow;
  reg  [4:0]  mask_reg;
  reg  [11:0] ptr_reg;
  reg  [11:0] ptr_next;
  reg         wrap_reg;
  reg  [11:0] mark_reg;
  reg         auto_halt_reg;
  reg         auto_stop_reg;
  reg         mark_lock_reg;
  reg  [2:0]  state_reg;
  reg  [63:0] pkt_hold_reg;
  reg         dp_reg_reg;
  reg         dp_ram_reg;
  reg         dp_write_reg;
  reg         dp_priv_reg;
  reg  [11:0] dp_addr_reg;
  reg  [31:0] reg_rdata;
  reg         en_next;
  reg         lock_next;

  wire        start_lvl = pin_lvl_reg[0];
  wire        stop_lvl  = pin_lvl_reg[1];
  wire        dbg_lvl   = pin_lvl_reg[2];
  wire        ap_valid  = hready & htrans[1];
  wire        ap_priv   = hprot[`TBMC_HPROT_PRIV_BIT];
  wire        ram_ok    = ap_priv | ~buffer_privileged_only;
  wire        dp_ram_ok = dp_priv_reg | ~buffer_privileged_only;
  wire        reg_wr    = dp_reg_reg & dp_write_reg &
                          (dp_priv_reg | ~control_write_privileged);
  wire        wr_pos    = reg_wr & (dp_addr_reg == `TBMC_POSITION_OFF);
  wire        wr_mst    = reg_wr & (dp_addr_reg == `TBMC_MASTER_OFF);
  wire        wr_flow   = reg_wr & (dp_addr_reg == `TBMC_FLOW_OFF);
  wire [11:0] new_ptr   = hwdata[`TBMC_PTR_MSB:`TBMC_PTR_LSB];
  wire [11:0] new_mark  = hwdata[`TBMC_PTR_MSB:`TBMC_PTR_LSB];
  wire        mark_hit  = (ptr_reg == mark_reg);
  wire        pkt_done  = state_reg[2];
  // oversize masks collapse to the largest buffer
  wire [4:0]  mask_eff  = (mask_reg > `TBMC_MASK_MAX) ? `TBMC_MASK_MAX : mask_reg;
  wire [11:0] low_bits  = ({11'h000, 1'b1} << (mask_eff + 5'h01)) - 12'h001;
  wire        at_edge   = ((ptr_reg & low_bits) == low_bits);

  // three-stage pin synchroniser; level follows once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_pin
      wire pin_raw = (gi == 0) ? trace_start_in :
                     (gi == 1) ? trace_stop_in : invasive_debug_allow;
      always @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          pin_s1_reg[gi]  <= 1'b0;
          pin_s2_reg[gi]  <= 1'b0;
          pin_s3_reg[gi]  <= 1'b0;
          pin_lvl_reg[gi] <= 1'b0;
        end
        else
        begin
          pin_s1_reg[gi] <= pin_raw;
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          if (pin_s2_reg[gi] == pin_s3_reg[gi])
            pin_lvl_reg[gi] <= pin_s3_reg[gi];
        end
      end
    end
  endgenerate

  // pointer step: wrap only the masked low bits, upper bits stay put
  always @*
  begin
    if (at_edge)
      ptr_next = ptr_reg & ~low_bits;
    else
      ptr_next = ptr_reg + 12'h001;
  end

  // enable and autostop lock; a stop acts only between packet writes
  always @*
  begin
    en_next   = en_reg;
    lock_next = mark_lock_reg;
    // software moving pointer or watermark releases the lock
    if ((wr_pos && new_ptr != ptr_reg) || (wr_flow && new_mark != mark_reg))
      lock_next = 1'b0;
    if (wr_mst)
      en_next = hwdata[`TBMC_MASTER_EN_BIT];
    if (start_input_allow && start_lvl && !mark_lock_reg)
      en_next = 1'b1;
    if (state_reg[0] || pkt_done)
    begin
      if (stop_input_allow && stop_lvl)
        en_next = 1'b0;
      if (auto_stop_reg && mark_hit && en_reg)
      begin
        en_next   = 1'b0;
        lock_next = 1'b1;
      end
    end
  end

  // master control register
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      en_reg                   <= 1'b0;
      mark_lock_reg            <= 1'b0;
      halt_request_bit         <= 1'b0;
      buffer_privileged_only   <= 1'b0;
      control_write_privileged <= 1'b0;
      stop_input_allow         <= 1'b0;
      start_input_allow        <= 1'b0;
      mask_reg                 <= 5'h00;
    end
    else
    begin
      en_reg        <= en_next;
      mark_lock_reg <= lock_next;
      if (wr_mst)
      begin
        buffer_privileged_only   <= hwdata[`TBMC_MASTER_BPRIV_BIT];
        control_write_privileged <= hwdata[`TBMC_MASTER_WPRIV_BIT];
        stop_input_allow         <= hwdata[`TBMC_MASTER_STOP_BIT];
        start_input_allow        <= hwdata[`TBMC_MASTER_START_BIT];
        mask_reg <= hwdata[`TBMC_MASTER_MASK_MSB:`TBMC_MASTER_MASK_LSB];
      end
      // hardware set beats a software clear in the same cycle
      if (auto_halt_reg && mark_hit)
        halt_request_bit <= 1'b1;
      else if (wr_mst)
        halt_request_bit <= hwdata[`TBMC_MASTER_HALT_BIT];
    end
  end

  // position and flow; a software pointer write beats the packet advance
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_reg       <= 12'h000;
      wrap_reg      <= 1'b0;
      mark_reg      <= 12'h000;
      auto_halt_reg <= 1'b0;
      auto_stop_reg <= 1'b0;
    end
    else
    begin
      if (wr_pos)
      begin
        ptr_reg  <= new_ptr;
        wrap_reg <= hwdata[`TBMC_WRAP_BIT];
      end
      else if (pkt_done)
      begin
        ptr_reg <= ptr_next;
        if (at_edge)
          wrap_reg <= 1'b1;
      end
      if (wr_flow)
      begin
        mark_reg      <= new_mark;
        auto_halt_reg <= hwdata[`TBMC_FLOW_HALT_BIT];
        auto_stop_reg <= hwdata[`TBMC_FLOW_STOP_BIT];
      end
    end
  end

  // packet writer: low word then high word, pointer moves after the high word
  assign pkt_ready = en_reg & state_reg[0] & ~(auto_stop_reg & mark_hit);
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg       <= ST_IDLE;
      pkt_hold_reg    <= 64'h0000_0000_0000_0000;
      trace_ram_we    <= 1'b0;
      trace_ram_addr  <= 13'h0000;
      trace_ram_wdata <= 32'h0000_0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          trace_ram_we <= 1'b0;
          if (pkt_valid && pkt_ready) // with autostop set, a pointer sitting on the mark takes nothing
          begin
            pkt_hold_reg    <= pkt_data;
            trace_ram_we    <= 1'b1;
            trace_ram_addr  <= {ptr_reg, 1'b0};
            trace_ram_wdata <= pkt_data[31:0];
            state_reg       <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          trace_ram_we    <= 1'b1;
          trace_ram_addr  <= {ptr_reg, 1'b1};
          trace_ram_wdata <= pkt_hold_reg[63:32];
          state_reg       <= ST_HIGH;
        end
        ST_HIGH:
        begin
          trace_ram_we <= 1'b0;
          state_reg    <= ST_IDLE;
        end
        default:
        begin
          trace_ram_we <= 1'b0;
          state_reg    <= ST_IDLE;
        end
      endcase
    end
  end

  // ahb address phase captured for the data phase
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dp_reg_reg   <= 1'b0;
      dp_ram_reg   <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_priv_reg  <= 1'b0;
      dp_addr_reg  <= 12'h000;
    end
    else if (hready)
    begin
      dp_reg_reg   <= ap_valid & hsel_reg;
      dp_ram_reg   <= ap_valid & hsel_ram;
      dp_write_reg <= hwrite;
      dp_priv_reg  <= ap_priv;
      dp_addr_reg  <= haddr;
    end
  end

  // register read mux; reads never checked for privilege, unmapped reads zero
  always @*
  begin
    case (dp_addr_reg)
      `TBMC_POSITION_OFF: reg_rdata = {17'h00000, ptr_reg, wrap_reg, 2'b00};
      `TBMC_MASTER_OFF:   reg_rdata = {en_reg, 21'h000000, halt_request_bit,
                                       buffer_privileged_only, control_write_privileged,
                                       stop_input_allow, start_input_allow,
                                       mask_reg};
      `TBMC_FLOW_OFF:     reg_rdata = {17'h00000, mark_reg, 1'b0, auto_halt_reg,
                                       auto_stop_reg};
      default:            reg_rdata = 32'h0000_0000;
    endcase
  end

  // ram path: user accesses read zero and never write when restricted
  assign bus_ram_en    = ap_valid & hsel_ram & ram_ok & ~hwrite;
  assign bus_ram_addr  = haddr[11:2];
  assign bus_ram_we    = dp_ram_reg & dp_write_reg & dp_ram_ok;
  assign bus_ram_wdata = hwdata;
  assign hrdata        = dp_reg_reg ? reg_rdata :
                         (dp_ram_reg && dp_ram_ok) ? bus_ram_rdata : 32'h0000_0000;
  assign hready_out    = 1'b1;
  assign hresp         = 1'b0;

  // halt leaves only while invasive debug is allowed
  assign debug_halt_out = halt_request_bit & dbg_lvl;

endmodule // tbmc_master_ctrl

// ===== verification/tbmc_master_ctrl_chk.sv
`timescale 1ns/1ps
module tbmc_chk (
  input wire        sys_clk,
  input wire        rst,
  input wire        hsel_reg,
  input wire        hsel_ram,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [3:0]  hprot,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hready_out,
  input wire        hresp,
  input wire        bus_ram_en,
  input wire [9:0]  bus_ram_addr,
  input wire        pkt_valid,
  input wire        pkt_ready,
  input wire [63:0] pkt_data,
  input wire        trace_ram_we,
  input wire [12:0] trace_ram_addr,
  input wire [31:0] trace_ram_wdata,
  input wire        invasive_debug_allow,
  input wire        debug_halt_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire tk = pkt_valid & pkt_ready;
  wire rd = hready & htrans[1] & !hwrite;
  reg  rdm_reg;
  reg  rru_reg;
  // data phase flags: master read, refused user ram read
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdm_reg <= 1'b0;
      rru_reg <= 1'b0;
    end
    else
    begin
      rdm_reg <= rd & hsel_reg & (haddr == 12'h004);
      rru_reg <= rd & hsel_ram & !hprot[1] & !bus_ram_en;
    end
  end
  pkt_pair_a: assert property (tk |=> trace_ram_we ##1 trace_ram_we ##1 !trace_ram_we)
    else $error("packet did not give two write pulses");
  word_order_a: assert property (tk |=> !trace_ram_addr[0] &&
    trace_ram_wdata == $past(pkt_data[31:0]) ##1 trace_ram_addr[0] &&
    trace_ram_wdata == $past(pkt_data[63:32], 2))
    else $error("packet words out of order");
  busy_hold_a: assert property (tk |=> !pkt_ready [*2])
    else $error("packet taken while writer busy");
  ptr_same_a: assert property (tk |=> ##1 trace_ram_addr[12:1] == $past(trace_ram_addr[12:1]))
    else $error("packet words at different pointers");
  rsvd_zero_a: assert property (rdm_reg |-> hrdata[30:10] == 21'h0)
    else $error("reserved master bits not zero");
  user_raz_a: assert property (rru_reg |-> hrdata == 32'h0)
    else $error("refused user ram read not zero");
  priv_ram_a: assert property (rd & hsel_ram & hprot[1] |->
    bus_ram_en && bus_ram_addr == haddr[11:2])
    else $error("privileged ram read not passed");
  halt_gate_a: assert property (!invasive_debug_allow [*5] |-> !debug_halt_out)
    else $error("halt out without debug allow");
  bus_okay_a: assert property (hready_out && !hresp)
    else $error("bus answered with wait or error");
  cover property (tk);
  cover property (debug_halt_out);
  cover property (rru_reg);
endmodule // tbmc_chk

bind tbmc_master_ctrl tbmc_chk u_chk (.*);

// ===== verification/tbmc_core_model.sv
`timescale 1ns/1ps
module tbmc_core_model (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        go,
  input  wire [3:0]  n,
  output wire        busy,
  output reg         pkt_valid,
  input  wire        pkt_ready,
  output reg  [63:0] pkt_data,
  input  wire        bus_ram_en,
  input  wire        bus_ram_we,
  input  wire [9:0]  bus_ram_addr,
  input  wire [31:0] bus_ram_wdata,
  output reg  [31:0] bus_ram_rdata
);
  reg [31:0] mem [0:1023];
  reg [9:0]  wa_reg;
  reg [3:0]  left_reg;
  integer    seed = 53833;
  assign busy = left_reg != 4'h0;
  // write address comes from the address phase; idle read data toggles so stale data fails
  always @(posedge sys_clk)
  begin
    wa_reg <= bus_ram_addr;
    if (bus_ram_we)
      mem[wa_reg] <= bus_ram_wdata;
    bus_ram_rdata <= bus_ram_en ? mem[bus_ram_addr] : ~bus_ram_rdata;
  end
  // offer held until taken, random gaps; go reloads the count and withdraws an offer
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pkt_valid <= 1'b0;
      left_reg <= 4'h0;
      pkt_data <= 64'h0;
    end
    else if (go)
    begin
      pkt_valid <= 1'b0;
      left_reg <= n;
    end
    else if (pkt_valid & pkt_ready)
    begin
      pkt_valid <= 1'b0;
      left_reg <= left_reg - 4'h1;
      pkt_data <= ~pkt_data;
    end
    else if (!pkt_valid && busy && $random(seed) % 2 == 0)
    begin
      pkt_valid <= 1'b1;
      pkt_data <= {$random(seed), $random(seed)};
    end
  end
endmodule // tbmc_core_model

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg         sys_clk = 1'b0;
  reg         rst = 1'b1;
  reg         hsel_reg = 1'b0;
  reg         hsel_ram = 1'b0;
  reg  [11:0] haddr = 12'h000;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [3:0]  hprot = 4'h0;
  reg  [31:0] hwdata = 32'h0;
  reg         trace_start_in = 1'b0;
  reg         trace_stop_in = 1'b0;
  reg         invasive_debug_allow = 1'b0;
  reg         go = 1'b0;
  reg  [3:0]  n = 4'h0;
  reg         rd_reg = 1'b0;
  wire [31:0] hrdata, bus_ram_wdata, bus_ram_rdata;
  wire [9:0]  bus_ram_addr;
  wire [63:0] pkt_data;
  wire        bus_ram_en, bus_ram_we, pkt_valid, pkt_ready, debug_halt_out, busy;
  integer     seed = 53833;
  integer     fail_count = 0;
  integer     check_count = 0;
  integer     i, p, lo, lim, ex;
  reg  [4:0]  m;
  reg  [31:0] r;
  reg  [31:0] exp_q [$];
  localparam [24:0] MS = {5'h1f, 5'h0b, 5'h04, 5'h01, 5'h00};

  initial forever #2 sys_clk = ~sys_clk;
  tbmc_master_ctrl uut (.*, .hready(1'b1), .hready_out(), .hresp(), .trace_ram_we(),
    .trace_ram_addr(), .trace_ram_wdata());
  tbmc_core_model u_core (.*);

  task chk(input [31:0] got, input [31:0] want);
  begin
    check_count = check_count + 1;
    if (got !== want)
    begin
      fail_count = fail_count + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  end
  endtask
  // one bus word: address phase, then data phase; reads leave a note for the monitor
  task bus(input s, input w, input pv, input [11:0] a, input [31:0] d);
  begin
    @(posedge sys_clk);
    #1;
    {hsel_ram, hsel_reg, htrans, hwrite, haddr} = {s, !s, 2'h2, w, a};
    hprot = {2'h0, pv, 1'b1};
    if (!w)
      exp_q.push_back(d);
    @(posedge sys_clk);
    #1;
    {hsel_ram, hsel_reg, htrans} = 4'h0;
    hwdata = w ? d : ~d;
  end
  endtask
  task send(input [3:0] cnt, input fin);
    integer j;
  begin
    @(posedge sys_clk);
    #1;
    {go, n} = {1'b1, cnt};
    @(posedge sys_clk);
    #1;
    go = 1'b0;
    for (j = 0; j < 100 && busy; j = j + 1)
      @(posedge sys_clk);
    // pointer moves on the second edge after the last take
    repeat (4) @(posedge sys_clk);
    chk({31'h0, busy}, {31'h0, !fin});
    // a packet source that never drains is a timeout: report at once
    if (fin && busy)
      conclude;
  end
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // read data is judged at the edge closing its data phase
  always @(posedge sys_clk)
  begin
    if (rd_reg)
      chk(hrdata, exp_q.pop_front());
    rd_reg = htrans[1] & !hwrite & (hsel_reg | hsel_ram);
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    for (i = 0; i < 4; i = i + 1)
      bus(0, 0, 1, {i[9:0], 2'h0}, 32'h0);
    bus(0, 1, 1, 12'h004, 32'hffff_ffff);
    bus(0, 0, 1, 12'h004, 32'h8000_03ff);
    bus(0, 1, 1, 12'h004, 32'h0000_0080);
    bus(0, 1, 0, 12'h004, 32'h8000_0020);
    bus(0, 0, 0, 12'h004, 32'h0000_0080);
    r = $random(seed);
    bus(1, 1, 0, 12'h010, r);
    bus(1, 0, 0, 12'h010, r);
    bus(0, 1, 1, 12'h004, 32'h0000_0100);
    bus(1, 1, 0, 12'h010, ~r);
    bus(1, 0, 0, 12'h010, 32'h0);
    bus(1, 0, 1, 12'h010, r);
    bus(0, 1, 1, 12'h004, 32'h0);
    $display("register access test done");
    // random start pointer and packet count per mask, oversize mask included
    for (i = 0; i < 10; i = i + 1)
    begin
      m = MS[(i % 5) * 5 +: 5];
      lim = 2 << ((m > 5'h0b) ? 11 : m);
      p = $random(seed) & 32'hfff;
      r = 1 + ($random(seed) & 3);
      lo = (p & (lim - 1)) + r;
      ex = (p & ~(lim - 1)) | (lo & (lim - 1));
      bus(0, 1, 1, 12'h000, {17'h0, p[11:0], 3'h0});
      bus(0, 1, 1, 12'h004, {27'h400_0000, m});
      send(r[3:0], 1);
      bus(0, 1, 1, 12'h004, {27'h0, m});
      bus(0, 0, 1, 12'h000, {17'h0, ex[11:0], lo >= lim, 2'h0});
    end
    $display("pointer wrap test done");
    p = $random(seed) & 32'hffe;
    invasive_debug_allow = 1'b1;
    bus(0, 1, 1, 12'h000, {17'h0, p[11:0], 3'h0});
    bus(0, 1, 1, 12'h008, {17'h0, p[11:0] + 12'h1, 3'h3});
    bus(0, 1, 1, 12'h004, 32'h8000_002b);
    send(4'h3, 0);
    bus(0, 0, 1, 12'h000, {17'h0, p[11:0] + 12'h1, 3'h0});
    bus(0, 0, 1, 12'h004, 32'h0000_022b);
    chk({31'h0, debug_halt_out}, 32'h1);
    send(4'h0, 1);
    #1 trace_start_in = 1'b1;
    repeat (6) @(posedge sys_clk);
    bus(0, 0, 1, 12'h004, 32'h0000_022b);
    bus(0, 1, 1, 12'h000, {17'h0, p[11:0], 3'h0});
    repeat (6) @(posedge sys_clk);
    bus(0, 0, 1, 12'h004, 32'h8000_022b);
    trace_start_in = 1'b0;
    invasive_debug_allow = 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({31'h0, debug_halt_out}, 32'h0);
    bus(0, 1, 1, 12'h008, 32'h0);
    $display("watermark test done");
    bus(0, 1, 1, 12'h004, 32'h0000_006b);
    trace_start_in = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 trace_start_in = 1'b0;
    bus(0, 0, 1, 12'h004, 32'h8000_006b);
    @(posedge sys_clk);
    #1 {go, n} = {1'b1, 4'h9};
    @(posedge sys_clk);
    #1 go = 1'b0;
    repeat (7) @(posedge sys_clk);
    #1 trace_stop_in = 1'b1;
    repeat (8) @(posedge sys_clk);
    bus(0, 0, 1, 12'h004, 32'h0000_006b);
    trace_stop_in = 1'b0;
    send(4'h0, 1);
    $display("start stop pin test done");
    conclude;
  end
endmodule // tb_top
